// [design/eepc_ctrl.sv]
// eepc_ctrl: control register, capture latch and 240-byte array for program/erase
// assumes: APB slave on pclk; EEPROM bus is a simple same-clock read/write port
//
// Operation
// R1: pump output follows pump enable bit
// R2: setting capture bit also sets pump bit
// R3: array power only while power bit set
// R4: software clears pump when idle
// R5: two select bits choose program or erase kind
// R6: select bits read/write, zero after reset
// R7: byte erase clears only captured byte
// R8: block erase clears captured 64-byte block
// R9: bulk erase clears all 240 bytes
// R10: capture bit latches address and data of write
// R11: reads blocked while capture bit set
// R12: rc select picks timing clock source
// R13: software sets rc below 1.5 MHz, waits
// R14: power bit needs capture, clears without it
// R15: capture and power set in separate writes
// R16: uncaptured write leaves array unchanged
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module eepc_ctrl
  import eepc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        nv_wr,
  input  wire logic        nv_rd,
  input  wire logic [11:0] nv_addr,
  input  wire logic [7:0]  nv_wdata,
  output logic [7:0]       nv_rdata,
  output logic             nv_rvalid,
  output logic             charge_pump_on,
  output logic             array_power_on,
  output logic             nv_clk_sel_rc
);

  typedef struct packed {
    logic       pump;
    logic [1:0] erase_sel;
    logic       latch;
    logic       rc;
    logic       pwr;
    logic       cap_valid;
    logic [7:0] cap_idx;
    logic [7:0] cap_data;
    logic       op_done;
    logic [7:0] rdata;
    logic       rvalid;
    logic [31:0] prdata;
  } eepc_state_type;

  eepc_state_type st_ff;
  eepc_state_type nxt_st;
  logic [7:0] mem_ff [0:239];

  function automatic logic in_array(input logic [11:0] a);
    in_array = (a >= EEPC_ARRAY_BASE) && (a <= EEPC_ARRAY_LAST);
  endfunction

  function automatic logic [7:0] arr_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - EEPC_ARRAY_BASE;
    arr_idx = d[7:0];
  endfunction

  function automatic logic [7:0] ctrl_value(input eepc_state_type s);
    ctrl_value = 8'h00;
    ctrl_value[EEPC_BIT_PUMP]  = s.pump;
    ctrl_value[EEPC_BIT_ERHI]  = s.erase_sel[1];
    ctrl_value[EEPC_BIT_ERLO]  = s.erase_sel[0];
    ctrl_value[EEPC_BIT_LATCH] = s.latch;
    ctrl_value[EEPC_BIT_RC]    = s.rc;
    ctrl_value[EEPC_BIT_PWR]   = s.pwr;
  endfunction

  logic acc;
  logic reg_hit;
  logic apply;
  assign acc     = psel && penable;
  assign reg_hit = (paddr == EEPC_CTRL_ADDR);
  // program/erase applies once power is up on a captured write, one shot per power-up
  // the pump must run too: without it no programming voltage exists to apply
  assign apply   = st_ff.pump && st_ff.pwr && st_ff.cap_valid && !st_ff.op_done; // R3 R16

  always_comb
  begin
    logic [7:0] w;
    w = pwdata[7:0];
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    // loaded in the setup cycle so the word already stands when the access completes
    if (psel && !penable && !pwrite)
    begin
      nxt_st.prdata = reg_hit ? {24'h000000, ctrl_value(st_ff)} : 32'h00000000;
    end
    if (acc && pwrite && reg_hit)
    begin
      nxt_st.erase_sel = {w[EEPC_BIT_ERHI], w[EEPC_BIT_ERLO]}; // R5 R6
      nxt_st.rc = w[EEPC_BIT_RC]; // R12
      nxt_st.latch = w[EEPC_BIT_LATCH];
      nxt_st.pump = w[EEPC_BIT_PUMP] || (w[EEPC_BIT_LATCH] && !st_ff.latch); // R2
      // power may only be raised when capture was already on before this write
      nxt_st.pwr = w[EEPC_BIT_PWR] && st_ff.latch && w[EEPC_BIT_LATCH]; // R14
      if (!w[EEPC_BIT_PWR])
      begin
        nxt_st.op_done = 1'b0;
      end
    end
    if (!nxt_st.latch)
    begin
      nxt_st.pwr = 1'b0; // R14
      nxt_st.cap_valid = 1'b0;
      nxt_st.op_done = 1'b0;
    end
    if (st_ff.latch && nv_wr && in_array(nv_addr))
    begin
      nxt_st.cap_valid = 1'b1; // R10
      nxt_st.cap_idx = arr_idx(nv_addr);
      nxt_st.cap_data = nv_wdata;
    end
    if (apply)
    begin
      nxt_st.op_done = 1'b1;
    end
    if (nv_rd && in_array(nv_addr))
    begin
      nxt_st.rvalid = 1'b1;
      // reads give zero while capture is on, so no half-programmed byte leaks
      nxt_st.rdata = st_ff.latch ? 8'h00 : mem_ff[arr_idx(nv_addr)]; // R11
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0; // R6
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // array storage has no reset: contents model nonvolatile cells
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < 240; i++)
    begin
      if (apply)
      begin
        case (st_ff.erase_sel)
          EEPC_MODE_PROG:
          begin
            if (i == int'(st_ff.cap_idx))
            begin
              mem_ff[i] <= st_ff.cap_data; // R5
            end
          end
          EEPC_MODE_BYTE:
          begin
            if (i == int'(st_ff.cap_idx))
            begin
              mem_ff[i] <= EEPC_ERASED; // R7
            end
          end
          EEPC_MODE_BLOCK:
          begin
            if ((i >> EEPC_BLOCK_SHIFT) == (int'(st_ff.cap_idx) >> EEPC_BLOCK_SHIFT))
            begin
              mem_ff[i] <= EEPC_ERASED; // R8
            end
          end
          EEPC_MODE_BULK:
          begin
            mem_ff[i] <= EEPC_ERASED; // R9
          end
          default:
          begin
            mem_ff[i] <= mem_ff[i];
          end
        endcase
      end
    end
  end

  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  assign prdata         = st_ff.prdata;
  assign nv_rdata       = st_ff.rdata;
  assign nv_rvalid      = st_ff.rvalid;
  assign charge_pump_on = st_ff.pump; // R1
  assign array_power_on = st_ff.pump && st_ff.pwr; // R3
  assign nv_clk_sel_rc  = st_ff.rc; // R12

  a_pump_follows: assert property (@(posedge pclk) disable iff (!presetn) // R1
    acc && pwrite && reg_hit
    |=> charge_pump_on == ($past(pwdata[EEPC_BIT_PUMP]) || ($past(pwdata[EEPC_BIT_LATCH]) && !$past(st_ff.latch))))
    else $error("pump output mismatch");
  a_latch_starts_pump: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && reg_hit && pwdata[EEPC_BIT_LATCH] && !st_ff.latch |=> charge_pump_on)
    else $error("capture did not start pump"); // R2
  a_power_gated: assert property (@(posedge pclk) disable iff (!presetn)
    array_power_on |-> st_ff.pwr && charge_pump_on) else $error("power without bit"); // R3
  a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && reg_hit |=> st_ff.erase_sel == $past(pwdata[4:3]))
    else $error("select not stored"); // R6
  a_pwr_needs_latch: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.pwr |-> st_ff.latch) else $error("power without capture"); // R14
  a_no_same_write: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && reg_hit && !st_ff.latch |=> !st_ff.pwr) else $error("power set with capture"); // R14
  a_capture_write: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.latch && nv_wr && in_array(nv_addr) && !(acc && pwrite && reg_hit)
    |=> st_ff.cap_valid && st_ff.cap_data == $past(nv_wdata)) else $error("write not captured"); // R10
  a_read_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    nv_rd && in_array(nv_addr) && st_ff.latch |=> nv_rvalid && nv_rdata == 8'h00)
    else $error("read during capture"); // R11
  a_rc_select: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && reg_hit |=> nv_clk_sel_rc == $past(pwdata[1])) else $error("rc select"); // R12
  a_apply_once: assert property (@(posedge pclk) disable iff (!presetn)
    apply |=> !apply) else $error("operation repeated"); // R16

  // pump, select and rc bits move only on a register write
  a_pump_holds: assert property (@(posedge pclk) disable iff (!presetn) // R1
    !(acc && pwrite && reg_hit)
    |=> $stable(charge_pump_on))
    else $error("pump changed without write");

  a_sel_holds: assert property (@(posedge pclk) disable iff (!presetn) // R6
    !(acc && pwrite && reg_hit)
    |=> $stable(st_ff.erase_sel))
    else $error("select changed without write");

  a_rc_holds: assert property (@(posedge pclk) disable iff (!presetn) // R12
    !(acc && pwrite && reg_hit)
    |=> $stable(nv_clk_sel_rc))
    else $error("rc select changed without write");

  a_latch_write: assert property (@(posedge pclk) disable iff (!presetn) // R10
    acc && pwrite && reg_hit
    |=> st_ff.latch == $past(pwdata[EEPC_BIT_LATCH]))
    else $error("capture bit not stored");

  // power side: never without capture, never without pump
  a_power_drop: assert property (@(posedge pclk) disable iff (!presetn) // R14
    !st_ff.latch
    |-> !array_power_on)
    else $error("power on without capture");

  a_pwr_clears: assert property (@(posedge pclk) disable iff (!presetn) // R14
    acc && pwrite && reg_hit && !pwdata[EEPC_BIT_LATCH]
    |=> !array_power_on)
    else $error("power kept after capture cleared");

  a_apply_power: assert property (@(posedge pclk) disable iff (!presetn) // R3
    apply
    |-> array_power_on)
    else $error("array changed without power");

  a_idle_capture: assert property (@(posedge pclk) disable iff (!presetn) // R16
    !st_ff.latch
    |-> !st_ff.cap_valid)
    else $error("capture held while idle");

  a_idle_array: assert property (@(posedge pclk) disable iff (!presetn) // R16
    !st_ff.latch
    |-> !apply)
    else $error("array changed while idle");

  a_capture_addr: assert property (@(posedge pclk) disable iff (!presetn) // R10
    st_ff.latch && nv_wr && in_array(nv_addr) && !(acc && pwrite && reg_hit)
    |=> st_ff.cap_idx == $past(arr_idx(nv_addr)))
    else $error("address not captured");

  // array effects; program, byte and block checked only where the captured byte cannot move under them, bulk always
  a_prog_byte: assert property (@(posedge pclk) disable iff (!presetn) // R5
    apply && st_ff.erase_sel == EEPC_MODE_PROG && !nv_wr
    |=> mem_ff[st_ff.cap_idx] == st_ff.cap_data)
    else $error("byte not programmed");

  a_byte_erase: assert property (@(posedge pclk) disable iff (!presetn) // R7
    apply && st_ff.erase_sel == EEPC_MODE_BYTE && !nv_wr
    |=> mem_ff[st_ff.cap_idx] == EEPC_ERASED)
    else $error("byte not erased");

  a_block_erase: assert property (@(posedge pclk) disable iff (!presetn) // R8
    apply && st_ff.erase_sel == EEPC_MODE_BLOCK && !nv_wr
    |=> mem_ff[{st_ff.cap_idx[7:6], 6'h00}] == EEPC_ERASED)
    else $error("block not erased");

  a_bulk_erase: assert property (@(posedge pclk) disable iff (!presetn) // R9
    apply && st_ff.erase_sel == EEPC_MODE_BULK
    |=> mem_ff[0] == EEPC_ERASED && mem_ff[239] == EEPC_ERASED)
    else $error("array not bulk erased");

  // read side of the array port
  a_read_normal: assert property (@(posedge pclk) disable iff (!presetn) // R11
    nv_rd && in_array(nv_addr)
    |=> nv_rvalid)
    else $error("read not answered");

  a_read_idle: assert property (@(posedge pclk) disable iff (!presetn) // R11
    !(nv_rd && in_array(nv_addr))
    |=> !nv_rvalid)
    else $error("read answer without read");

  // register read path
  a_reg_readback: assert property (@(posedge pclk) disable iff (!presetn) // R6
    psel && !penable && !pwrite && reg_hit
    |=> prdata[4:3] == $past(st_ff.erase_sel))
    else $error("select bits not read back");

  a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn) // R6
    psel && !penable && !pwrite && !reg_hit
    |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

  c_program: cover property (@(posedge pclk) disable iff (!presetn) apply && st_ff.erase_sel == EEPC_MODE_PROG);
  c_byte: cover property (@(posedge pclk) disable iff (!presetn) apply && st_ff.erase_sel == EEPC_MODE_BYTE);
  c_block: cover property (@(posedge pclk) disable iff (!presetn) apply && st_ff.erase_sel == EEPC_MODE_BLOCK);
  c_bulk: cover property (@(posedge pclk) disable iff (!presetn) apply && st_ff.erase_sel == EEPC_MODE_BULK);
  c_read: cover property (@(posedge pclk) disable iff (!presetn) nv_rvalid && !st_ff.latch);

endmodule
`default_nettype wire

// [design/eepc_pkg.sv]
// eepc_pkg: constants for the nonvolatile program/erase control block
// assumes: 8-bit control register reached over a 32-bit APB slave
package eepc_pkg;
  localparam logic [11:0] EEPC_CTRL_IDX    = 12'h01B;
  localparam logic [11:0] EEPC_CTRL_ADDR   = 12'h06C;
  localparam logic [11:0] EEPC_ARRAY_BASE  = 12'h300;
  localparam logic [11:0] EEPC_ARRAY_LAST  = 12'h3EF;
  localparam logic [7:0]  EEPC_ARRAY_SIZE  = 8'hF0;
  localparam int          EEPC_BLOCK_SHIFT = 6;
  localparam int          EEPC_BIT_PUMP    = 6;
  localparam int          EEPC_BIT_ERHI    = 4;
  localparam int          EEPC_BIT_ERLO    = 3;
  localparam int          EEPC_BIT_LATCH   = 2;
  localparam int          EEPC_BIT_RC      = 1;
  localparam int          EEPC_BIT_PWR     = 0;
  localparam logic [7:0]  EEPC_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  EEPC_ERASED      = 8'hFF;
  localparam logic [1:0]  EEPC_MODE_PROG   = 2'h0;
  localparam logic [1:0]  EEPC_MODE_BYTE   = 2'h1;
  localparam logic [1:0]  EEPC_MODE_BLOCK  = 2'h2;
  localparam logic [1:0]  EEPC_MODE_BULK   = 2'h3;
endpackage

// [verification/eeprom_program_erase_control_tb.sv]
// self-checking bench for the program/erase control block
// assumes: zero-wait APB slave, one-cycle nv strobes, array starts unknown
`timescale 1ns/10ps
`default_nettype none
module eeprom_program_erase_control_tb;
  import eepc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        nv_wr, nv_rd, nv_rvalid, pump, pwr, rc;
  logic [11:0] paddr, nv_addr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  nv_wdata, nv_rdata;
  int          n_fail = 0, checks = 0, cyc = 0;

  eepc_ctrl u_eepc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .nv_wr(nv_wr), .nv_rd(nv_rd), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata), .nv_rvalid(nv_rvalid), .charge_pump_on(pump),
    .array_power_on(pwr), .nv_clk_sel_rc(rc));

  initial
  begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end

  task report_and_stop;
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    // one idle edge keeps the next setup from re-raising psel in this step
    @(posedge pclk);
  endtask

  task nvw(input logic [11:0] a, input logic [7:0] d);
    nv_wr <= 1;
    nv_addr <= a;
    nv_wdata <= d;
    @(posedge pclk) nv_wr <= 0;
    @(posedge pclk);
  endtask

  task nvr(input logic [11:0] a, input logic [7:0] e);
    nv_rd <= 1;
    nv_addr <= a;
    @(posedge pclk) nv_rd <= 0;
    #1;
    chk({nv_rvalid, nv_rdata}, {1'b1, e});
    @(posedge pclk);
  endtask

  task op(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d);
    apb(1, EEPC_CTRL_ADDR, {3'h0, m, 3'h4});
    nvw(a, d);
    apb(1, EEPC_CTRL_ADDR, {2'h1, 1'b0, m, 3'h5});
    repeat (2) @(posedge pclk);
    chk(pwr, 1);
    apb(1, EEPC_CTRL_ADDR, 8'h00);
  endtask

  task reg_bits;
    apb(0, EEPC_CTRL_ADDR, 8'h00);
    chk(r, 32'h0);
    apb(1, EEPC_CTRL_ADDR, 8'h18);
    apb(0, EEPC_CTRL_ADDR, 8'h00);
    chk(r, 32'h18);
    apb(1, EEPC_CTRL_ADDR, 8'h19);
    apb(0, EEPC_CTRL_ADDR, 8'h00);
    chk(r, 32'h18);
    apb(1, EEPC_CTRL_ADDR, 8'h04);
    apb(0, EEPC_CTRL_ADDR, 8'h00);
    chk(r, 32'h44);
    chk({pump, pwr}, 2'h2);
    nvr(12'h305, 8'h00);
    apb(1, EEPC_CTRL_ADDR, 8'h00);
    chk(pump, 0);
    apb(1, EEPC_CTRL_ADDR, 8'h02);
    chk(rc, 1);
    apb(0, 12'h070, 8'h00);
    chk(r, 32'h0);
  endtask

  task erase_modes;
    op(EEPC_MODE_PROG, 12'h305, 8'h5A);
    op(EEPC_MODE_PROG, 12'h306, 8'hA5);
    op(EEPC_MODE_PROG, 12'h345, 8'h11);
    nvr(12'h305, 8'h5A);
    op(EEPC_MODE_BYTE, 12'h305, 8'h00);
    nvr(12'h305, EEPC_ERASED);
    nvr(12'h306, 8'hA5);
    op(EEPC_MODE_BLOCK, 12'h33F, 8'h00);
    nvr(12'h306, EEPC_ERASED);
    nvr(12'h345, 8'h11);
    nvw(12'h345, 8'h00);
    nvr(12'h345, 8'h11);
    op(EEPC_MODE_BULK, 12'h3EF, 8'h00);
    nvr(12'h345, EEPC_ERASED);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, nv_wr, nv_rd} = 6'h00;
    {paddr, nv_addr, pwdata, nv_wdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    reg_bits;
    erase_modes;
    report_and_stop;
  end
endmodule
`default_nettype wire
